/* File: mfla_pkg.sv */
// package: constants, types and word layouts of the fault log access block
package mfla_pkg;

    // ****************************************************************
    // word layout: bit 0 is the most significant bit of a 16-bit word
    // ****************************************************************
    localparam int WORD_W       = 16;
    localparam int ADDR_W       = 10;
    // a field at documented bit n sits at vector index 15-n
    localparam int CTL_MCLR_POS = 15;   // control bit 0: master clear
    localparam int CTL_COPY_POS = 13;   // control bit 2: map-to-buffer copy
    localparam int CTL_SCAN_POS = 12;   // control bit 3: buffer scan
    localparam int CTL_ECC_POS  = 11;   // control bit 4: ecc write disable
    localparam int HALF_POS     = 10;   // bit 5: map half select
    localparam int WR_DATA_POS  = 15;   // write bit 0: data bit
    localparam int WR_COPY_POS  = 13;   // write bit 2: buffer-to-map copy
    localparam int WR_FILL_POS  = 12;   // write bit 3: block fill
    localparam int WR_ONE_POS   = 11;   // write bit 4: single location write
    localparam int RB_FOUND_POS = 15;   // readback bit 0: set location found
    localparam int RB_READY_POS = 14;   // readback bit 1: ready
    localparam int RB_SCAN_POS  = 12;   // readback bit 3: scan in progress
    localparam int RB_ECC_POS   = 11;   // readback bit 4: ecc write disable
    localparam int RB_HALF_POS  = 10;   // readback bit 5: half select
    localparam int RB_CERR_POS  = 8;    // status bit 7: copy error

    // ****************************************************************
    // reset values and timing
    // ****************************************************************
    localparam logic [9:0] ADDR_RST   = 10'h000;
    localparam logic [9:0] ADDR_LAST  = 10'h3FF;
    localparam int CLK_MHZ            = 125;
    localparam int COPY_READY_US      = 50;   // longest time, rounds down
    localparam int SCAN_READY_US      = 2;    // fixed time
    localparam int COPY_READY_CYC     = COPY_READY_US * CLK_MHZ;
    localparam int SCAN_READY_CYC     = SCAN_READY_US * CLK_MHZ;

    typedef enum logic [2:0] {
        MFLA_IDLE, MFLA_RCOPY, MFLA_WCOPY, MFLA_SCAN, MFLA_FILL, MFLA_WAIT
    } mfla_state_t;

    // command strobes from the i/o processor bus
    typedef struct packed {
        logic                control_command;
        logic                write_command;
        logic                readback_command;
        logic [WORD_W-1:0]   word;
    } mfla_cmd_t;

    // map port toward the memory controller boards
    typedef struct packed {
        logic                rd;
        logic                wr;
        logic                half;
        logic [ADDR_W-1:0]   addr;
        logic                wdata;
    } mfla_map_t;
endpackage : mfla_pkg

/* File: mfla_buffer.sv */
// local 1024-location one-bit buffer in flip-flops
`timescale 1ns/1ps
module mfla_buffer #(
    parameter int DEPTH = 1024,
    parameter int AW    = 10
) (
    input  wire logic          sys_clk,   // system clock
    input  wire logic          we,        // write strobe
    input  wire logic [AW-1:0] waddr,     // write location
    input  wire logic          wdata,     // bit to store
    input  wire logic [AW-1:0] raddr,     // read location
    output logic               rdata      // bit at read location
);
    logic [DEPTH-1:0] mem_ff;

    // contents are not reset; the host fills the buffer before use
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem_ff[waddr] <= wdata;
        end
    end

    assign rdata = mem_ff[raddr];
endmodule : mfla_buffer

/* File: mfla_core.sv */
// fault log access: command decode, copy, scan and fill sequencer
//
// Notes on behaviour
// - control commands only when ready, except master clear, taken any time
// - master clear resets, aborts copy, scan, ecc disable; blocks them in its word
// - map-to-buffer copy runs start address to last, ends at counter wrap
// - ready low during copy, back within 50 us after completion
// - power fail, power on, i/o reset or master clear end a copy
// - copy together with scan in one word: only the copy runs
// - scan runs start to last location, pausing at each set location
// - after the readback of a paused scan, the scan resumes
// - ready low during scan, high two us after pause or completion
// - control bit 4 sets ecc write disable, driven to all controllers
// - ecc disable clears on resets, copy completion, master clear, bit 4 zero
// - bit 5 picks the map half, effective one clock later
// - every control command loads start address; master clear keeps it
// - buffer-to-map copy start to last, then counter set to zero
// - ready low during buffer-to-map copy, high 50 us after; clear aborts
// - block fill writes data bit start to last, zeroes counter, ready in 2 us
// - block fill overrides buffer-to-map copy and single write
// - single write stores data bit at address, counter unchanged
// - readback bit 0 marks a found location, bits 6-15 its address
// - readback reports ready, scan, ecc disable and half select
// - copy error bit set when map-to-buffer copy reads a set entry; control and write commands clear it
// - map strobes only in the clock after a refresh interval cycle, even if the window has closed
`timescale 1ns/1ps
module mfla_core #(
    parameter int COPY_CYC = mfla_pkg::COPY_READY_CYC,  // ready delay after copies
    parameter int SCAN_CYC = mfla_pkg::SCAN_READY_CYC   // ready delay after scan/fill
) (
    input  wire logic                    sys_clk,           // system clock
    input  wire logic                    reset,             // sync reset, high
    input  wire logic                    power_fail_warning, // power fail level
    input  wire logic                    power_on_event,    // power on level
    input  wire logic                    io_reset,          // i/o reset level
    input  wire mfla_pkg::mfla_cmd_t     cmd,               // command strobes and word
    input  wire logic                    refresh_window,    // map access permitted
    input  wire logic                    map_rdata,         // bit read from fault map
    output mfla_pkg::mfla_map_t          map_port,          // fault map access
    output logic                         ecc_write_disable, // to all controller boards
    output logic [15:0]                  status_word,       // status test answer
    output logic [15:0]                  scan_result_word   // readback answer
);
    import mfla_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        mfla_state_t       st;
        logic [ADDR_W-1:0] addr;
        logic              half;
        logic              ecc;
        logic              found;
        logic [ADDR_W-1:0] found_addr;
        logic              copy_err;
        logic              fill_bit;
        logic              rd_pend;    // map read strobe standing, data this cycle
        logic [ADDR_W-1:0] rd_addr;
        logic [15:0]       wait_cnt;
        mfla_map_t         map;
    } mfla_core_t;

    mfla_core_t r_ff, nxt_r;
    logic       buf_we;
    logic [9:0] buf_waddr;
    logic       buf_wdata;
    logic       buf_rdata;
    logic       ready;
    logic       abort;

    // read port follows the address counter, so scan and write copy see data at once
    mfla_buffer #(.DEPTH(1024), .AW(ADDR_W)) mfla_buffer_i (
        .sys_clk (sys_clk),
        .we      (buf_we),
        .waddr   (buf_waddr),
        .wdata   (buf_wdata),
        .raddr   (r_ff.addr),
        .rdata   (buf_rdata)
    );

    // field extraction, bit 0 most significant
    function automatic logic [ADDR_W-1:0] word_addr(input logic [15:0] w);
        return w[ADDR_W-1:0];
    endfunction : word_addr

    // copy states: the ones that power and i/o resets must end
    function automatic logic is_copy(input mfla_state_t s);
        return (s == MFLA_RCOPY) || (s == MFLA_WCOPY);
    endfunction : is_copy

    // a spent scan pause reads ready too; a command then ends the scan
    assign ready = (r_ff.st == MFLA_IDLE) |
                   (r_ff.st == MFLA_SCAN && r_ff.found && r_ff.wait_cnt == 16'h0000);
    assign abort = power_fail_warning | power_on_event | io_reset;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb begin
        nxt_r        = r_ff;
        nxt_r.map.rd = 1'b0;
        nxt_r.map.wr = 1'b0;
        nxt_r.rd_pend = 1'b0;
        buf_we       = 1'b0;
        buf_waddr    = r_ff.addr;
        buf_wdata    = r_ff.fill_bit;

        // map data answers in the cycle in which the read strobe stands
        if (r_ff.rd_pend) begin
            buf_we    = 1'b1;
            buf_waddr = r_ff.rd_addr;
            buf_wdata = map_rdata;
        end

        unique case (r_ff.st)
            MFLA_IDLE: begin
            end
            MFLA_RCOPY: begin
                // a read waits for a refresh window, so the copy stalls outside it
                if (refresh_window) begin
                    nxt_r.map.rd   = 1'b1;
                    nxt_r.map.addr = r_ff.addr;
                    nxt_r.rd_pend  = 1'b1;
                    nxt_r.rd_addr  = r_ff.addr;
                    nxt_r.addr     = r_ff.addr + 10'h001;
                    if (r_ff.addr == ADDR_LAST) begin
                        nxt_r.ecc      = 1'b0;
                        nxt_r.st       = MFLA_WAIT;
                        nxt_r.wait_cnt = 16'(COPY_CYC);
                    end
                end
            end
            MFLA_WCOPY: begin
                if (refresh_window) begin
                    nxt_r.map.wr    = 1'b1;
                    nxt_r.map.addr  = r_ff.addr;
                    nxt_r.map.wdata = buf_rdata;
                    nxt_r.addr      = r_ff.addr + 10'h001;
                    if (r_ff.addr == ADDR_LAST) begin
                        nxt_r.ecc      = 1'b0;
                        nxt_r.st       = MFLA_WAIT;
                        nxt_r.wait_cnt = 16'(COPY_CYC);
                    end
                end
            end
            MFLA_SCAN: begin
                // a found location holds the scan until it is read back
                if (!r_ff.found) begin
                    if (buf_rdata) begin
                        nxt_r.found      = 1'b1;
                        nxt_r.found_addr = r_ff.addr;
                        nxt_r.wait_cnt   = 16'(SCAN_CYC);
                    end else begin
                        nxt_r.addr = r_ff.addr + 10'h001;
                        if (r_ff.addr == ADDR_LAST) begin
                            nxt_r.st       = MFLA_WAIT;
                            nxt_r.wait_cnt = 16'(SCAN_CYC);
                        end
                    end
                end else if (r_ff.wait_cnt != 16'h0000) begin
                    nxt_r.wait_cnt = r_ff.wait_cnt - 16'h0001;
                end
            end
            MFLA_FILL: begin
                buf_we     = 1'b1;
                buf_waddr  = r_ff.addr;
                nxt_r.addr = r_ff.addr + 10'h001;
                if (r_ff.addr == ADDR_LAST) begin
                    nxt_r.st       = MFLA_WAIT;
                    nxt_r.wait_cnt = 16'(SCAN_CYC);
                end
            end
            MFLA_WAIT: begin
                // counter already wrapped to zero on the last location
                if (r_ff.wait_cnt <= 16'h0001) begin
                    nxt_r.st = MFLA_IDLE;
                end else begin
                    nxt_r.wait_cnt = r_ff.wait_cnt - 16'h0001;
                end
            end
            // codes 6 and 7 are unused; fall back to idle if ever reached
            default: begin
                nxt_r.st = MFLA_IDLE;
            end
        endcase

        // readback of a paused scan lets it resume once it completes
        if (cmd.readback_command && r_ff.st == MFLA_SCAN && r_ff.found) begin
            nxt_r.found = 1'b0;
            nxt_r.addr  = r_ff.addr + 10'h001;
            if (r_ff.addr == ADDR_LAST) begin
                nxt_r.st       = MFLA_WAIT;
                nxt_r.wait_cnt = 16'(SCAN_CYC);
            end
        end

        // control command; master clear is honoured even when busy
        if (cmd.control_command) begin
            nxt_r.copy_err = 1'b0;
            if (cmd.word[CTL_MCLR_POS]) begin
                nxt_r.st    = MFLA_IDLE;
                nxt_r.ecc   = 1'b0;
                nxt_r.found = 1'b0;
                nxt_r.rd_pend = 1'b0;
                // a strobe chosen this cycle must not reach the map
                nxt_r.map.rd  = 1'b0;
                nxt_r.map.wr  = 1'b0;
                nxt_r.half  = cmd.word[HALF_POS];
                // address left as it was                      
            end else if (ready) begin
                nxt_r.addr  = word_addr(cmd.word);
                nxt_r.half  = cmd.word[HALF_POS];
                nxt_r.ecc   = cmd.word[CTL_ECC_POS];
                nxt_r.found = 1'b0;
                // a command taken during a scan pause ends that scan
                nxt_r.st    = MFLA_IDLE;
                if (cmd.word[CTL_COPY_POS]) begin
                    nxt_r.st = MFLA_RCOPY;
                end else if (cmd.word[CTL_SCAN_POS]) begin
                    nxt_r.st = MFLA_SCAN;
                end
            end
        end else if (cmd.write_command && ready) begin
            nxt_r.copy_err = 1'b0;
            nxt_r.half     = cmd.word[HALF_POS];
            nxt_r.fill_bit = cmd.word[WR_DATA_POS];
            // a write taken in a scan pause ends the scan too
            nxt_r.found    = 1'b0;
            nxt_r.st       = MFLA_IDLE;
            if (cmd.word[WR_FILL_POS]) begin
                nxt_r.addr = word_addr(cmd.word);
                nxt_r.st   = MFLA_FILL;
            end else if (cmd.word[WR_COPY_POS]) begin
                nxt_r.addr = word_addr(cmd.word);
                nxt_r.st   = MFLA_WCOPY;
            end else if (cmd.word[WR_ONE_POS]) begin
                buf_we    = 1'b1;
                buf_waddr = word_addr(cmd.word);
                buf_wdata = cmd.word[WR_DATA_POS];
            end
        end

        // power and i/o resets end copies and drop ecc disable
        if (abort) begin
            nxt_r.ecc = 1'b0;
            if (is_copy(r_ff.st) || is_copy(nxt_r.st)) begin
                nxt_r.st      = MFLA_IDLE;
                // drop the strobe chosen this cycle so no access follows the cut
                nxt_r.map.rd  = 1'b0;
                nxt_r.map.wr  = 1'b0;
                nxt_r.rd_pend = 1'b0;
            end
        end

        // a set entry arriving wins over a clear by a command in the same cycle
        if (r_ff.rd_pend && map_rdata) begin
            nxt_r.copy_err = 1'b1;
        end
        nxt_r.map.half = nxt_r.half;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            r_ff <= '{st: MFLA_IDLE, addr: ADDR_RST, found_addr: ADDR_RST,
                      rd_addr: ADDR_RST, wait_cnt: 16'h0000, map: '0, default: 1'b0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // the status bit is the same ready level that gates commands
    logic ready_bit;
    assign ready_bit = ready;

    assign map_port          = r_ff.map;
    assign ecc_write_disable = r_ff.ecc;

    always_comb begin
        scan_result_word                       = 16'h0000;
        scan_result_word[RB_FOUND_POS]         = r_ff.found;
        scan_result_word[ADDR_W-1:0]           = r_ff.found_addr;
        scan_result_word[RB_READY_POS]         = ready_bit;
        scan_result_word[RB_SCAN_POS]          = (r_ff.st == MFLA_SCAN);
        scan_result_word[RB_ECC_POS]           = r_ff.ecc;
        scan_result_word[RB_HALF_POS]          = r_ff.half;
        status_word                            = 16'h0000;
        status_word[RB_READY_POS]              = ready_bit;
        status_word[RB_SCAN_POS]               = (r_ff.st == MFLA_SCAN);
        status_word[RB_ECC_POS]                = r_ff.ecc;
        status_word[RB_HALF_POS]               = r_ff.half;
        status_word[RB_CERR_POS]               = r_ff.copy_err;
    end
endmodule : mfla_core

/* File: mfla_core_chk.sv */
// checker: port-level assertions for the fault log access core
`timescale 1ns/1ps
module mfla_core_chk #(
    parameter int COPY_CYC = 20,                        // ready delay after copies
    parameter int SCAN_CYC = 5                          // ready delay after scan or fill
) (
    input wire logic                sys_clk,            // system clock
    input wire logic                reset,              // sync reset, high
    input wire logic                power_fail_warning, // power fail level
    input wire logic                power_on_event,     // power on level
    input wire logic                io_reset,           // i/o reset level
    input wire mfla_pkg::mfla_cmd_t cmd,                // command strobes and word
    input wire logic                refresh_window,     // map access permitted
    input wire logic                map_rdata,          // map read bit
    input wire mfla_pkg::mfla_map_t map_port,           // map access
    input wire logic                ecc_write_disable,  // ecc disable level
    input wire logic [15:0]         status_word,        // status answer
    input wire logic [15:0]         scan_result_word    // readback answer
);
    import mfla_pkg::*;
    // slack over the pause delay covers the register stages
    localparam int SCAN_LIM = SCAN_CYC + 3;
    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_map_refresh: assert property (
        (map_port.rd || map_port.wr) |-> (refresh_window || $past(refresh_window)))
        else $error("map access outside refresh window");
    a_clear_aborts: assert property (
        cmd.control_command && cmd.word[15] |=> !ecc_write_disable && !status_word[12])
        else $error("master clear left ecc disable or scan active");
    a_ecc_set: assert property (
        cmd.control_command && status_word[14] && !cmd.word[15] && cmd.word[11]
        |=> ecc_write_disable) else $error("ecc disable not set");
    a_ecc_clear: assert property (
        (io_reset || power_fail_warning || power_on_event) |=> !ecc_write_disable)
        else $error("ecc disable survived a reset line");
    a_half_select: assert property (
        cmd.control_command && (status_word[14] || cmd.word[15])
        |=> status_word[10] == $past(cmd.word[10])) else $error("half select wrong");
    a_copy_busy: assert property (
        cmd.control_command && status_word[14] && !cmd.word[15] && cmd.word[13]
        |=> !status_word[14] [*8]) else $error("ready high during copy");
    a_status_agree: assert property (
        status_word[14] == scan_result_word[14] && status_word[12:10] == scan_result_word[12:10])
        else $error("status and readback words disagree");
    a_found_hold: assert property (
        scan_result_word[15] && !cmd.readback_command && !cmd.control_command
        |=> scan_result_word[15] && $stable(scan_result_word[9:0]))
        else $error("found address lost before readback");
    a_scan_busy: assert property (
        status_word[12] && !scan_result_word[15] |-> !status_word[14])
        else $error("ready high while scanning");
    a_pause_ready: assert property (
        $rose(scan_result_word[15]) |-> ##[1:SCAN_LIM] status_word[14])
        else $error("ready late after scan pause");
endmodule : mfla_core_chk

/* File: mfla_map_model.sv */
// model of the memory controller fault map at the far side of the map port
`timescale 1ns/1ps
module mfla_map_model (
    input  wire logic                sys_clk,        // system clock
    input  wire mfla_pkg::mfla_map_t map_port,       // map access from the core
    output logic                     refresh_window, // refresh interval level
    output logic                     map_rdata       // bit read from the map
);
    import mfla_pkg::*;
    logic       mem [0:1][0:1023];  // two halves, preset by the bench
    logic [1:0] phase = 2'h0;        // refresh pattern phase
    logic       idle_bit = 1'b0;     // toggles while no read is answered
    int         rd_cnt = 0;          // map reads seen
    int         wr_cnt = 0;          // map writes seen
    initial refresh_window = 1'b0;
    // the core takes read data in the strobe's own cycle; otherwise a toggling bit
    assign map_rdata = map_port.rd ? mem[map_port.half][map_port.addr] : idle_bit;
    // one cycle in four is not refresh, so accesses must really wait
    always @(posedge sys_clk) begin
        phase <= phase + 2'h1;
        refresh_window <= (phase != 2'h3);
        idle_bit <= ~idle_bit;
        if (map_port.rd) begin
            rd_cnt <= rd_cnt + 1;
        end
        if (map_port.wr) begin
            mem[map_port.half][map_port.addr] <= map_port.wdata;
            wr_cnt <= wr_cnt + 1;
        end
    end
endmodule : mfla_map_model

/* File: test_memory_fault_log_access.sv */
// testbench: command sequences against the fault log access core
`timescale 1ns/1ps
module test_memory_fault_log_access;
    import mfla_pkg::*;
    logic                sys_clk = 1'b0;  // 125 mhz clock
    logic                reset = 1'b1;    // sync reset
    logic                power_fail_warning = 1'b0;
    logic                power_on_event = 1'b0;
    logic                io_reset = 1'b0;
    mfla_cmd_t           cmd = '0;        // command strobes
    logic                refresh_window;
    logic                map_rdata;
    mfla_map_t           map_port;
    logic                ecc_write_disable;
    logic [15:0]         status_word;
    logic [15:0]         scan_result_word;
    int                  mismatches = 0;
    int                  checks = 0;
    int                  cycles = 0;
    int                  n;
    // strobe codes: control, write, readback
    localparam logic [2:0] CTL = 3'b100, WR = 3'b010, RB = 3'b001;
    always #4 sys_clk = ~sys_clk;
    mfla_core #(.COPY_CYC(20), .SCAN_CYC(5)) mfla_core_i (
        .sys_clk(sys_clk), .reset(reset), .power_fail_warning(power_fail_warning),
        .power_on_event(power_on_event), .io_reset(io_reset), .cmd(cmd),
        .refresh_window(refresh_window), .map_rdata(map_rdata), .map_port(map_port),
        .ecc_write_disable(ecc_write_disable), .status_word(status_word),
        .scan_result_word(scan_result_word));
    mfla_map_model mfla_map_model_i (.sys_clk(sys_clk), .map_port(map_port),
        .refresh_window(refresh_window), .map_rdata(map_rdata));
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({15'h0000, got}, {15'h0000, exp});
    endtask : chk_bit
    // one-cycle strobe pulse; outputs are settled when the task returns
    task automatic send(input logic [2:0] s, input logic [15:0] w);
        @(posedge sys_clk);
        cmd <= {s, w};
        @(posedge sys_clk);
        cmd <= '0;
        #1;
    endtask : send
    // bounded wait for ready, or for a found location
    task automatic wait_for(input logic found);
        int k;
        for (k = 0; k < 3000 && (found ? scan_result_word[15] : status_word[14]) !== 1'b1; k++) begin
            @(posedge sys_clk);
            #1;
        end
        chk_bit(k < 3000, 1'b1);
    endtask : wait_for
    // hang guard well above the expected run length
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            complete_run();
        end
    end
    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        foreach (mfla_map_model_i.mem[h, a]) mfla_map_model_i.mem[h][a] = 1'b0;
        mfla_map_model_i.mem[0][10'h3FE] = 1'b1;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk_word(status_word, 16'h4000);
        send(CTL, 16'h3BFE);
        chk_bit(status_word[14], 1'b0);
        chk_bit(status_word[12], 1'b0);
        chk_bit(ecc_write_disable, 1'b1);
        wait_for(1'b0);
        chk_bit(ecc_write_disable, 1'b0);
        chk_bit(status_word[8], 1'b1);
        chk_word(16'(mfla_map_model_i.rd_cnt), 16'h0002);
        send(CTL, 16'h13FE);
        chk_bit(status_word[8], 1'b0);
        wait_for(1'b1);
        chk_word({scan_result_word[15], 5'h00, scan_result_word[9:0]}, 16'h83FE);
        wait_for(1'b0);
        chk_bit(status_word[12], 1'b1);
        send(RB, 16'h0000);
        wait_for(1'b0);
        chk_word(scan_result_word & 16'h9000, 16'h0000);
        // fill with copy and single write requested too: only the fill runs
        send(WR, 16'h3C00);
        wait_for(1'b0);
        chk_word(16'(mfla_map_model_i.wr_cnt), 16'h0000);
        send(WR, 16'h8A00);
        wait_for(1'b0);
        send(WR, 16'h25FF);
        chk_bit(status_word[14], 1'b0);
        wait_for(1'b0);
        chk_word(16'(mfla_map_model_i.wr_cnt), 16'h0201);
        chk_bit(mfla_map_model_i.mem[1][10'h200], 1'b1);
        chk_bit(mfla_map_model_i.mem[1][10'h1FF], 1'b0);
        chk_bit(status_word[10], 1'b1);
        send(CTL, 16'h1000);
        wait_for(1'b1);
        chk_word({scan_result_word[15], 5'h00, scan_result_word[9:0]}, 16'h8200);
        wait_for(1'b0);
        send(RB, 16'h0000);
        wait_for(1'b0);
        chk_bit(scan_result_word[15], 1'b0);
        // long copies cut short by master clear and by each reset line
        for (int i = 0; i < 4; i++) begin
            send(CTL, 16'h2000);
            repeat (12) @(posedge sys_clk);
            send(CTL, 16'h0800);
            chk_bit(ecc_write_disable, 1'b0);
            if (i == 0) begin
                send(CTL, 16'h8800);
            end else begin
                @(posedge sys_clk);
                power_fail_warning <= (i == 1);
                power_on_event <= (i == 2);
                io_reset <= (i == 3);
                @(posedge sys_clk);
                {power_fail_warning, power_on_event, io_reset} <= 3'b000;
                #1;
            end
            wait_for(1'b0);
            n = mfla_map_model_i.rd_cnt;
            repeat (20) @(posedge sys_clk);
            chk_word(16'(mfla_map_model_i.rd_cnt), 16'(n));
            chk_bit(ecc_write_disable, 1'b0);
        end
        complete_run();
    end
endmodule : test_memory_fault_log_access
bind mfla_core mfla_core_chk #(.COPY_CYC(COPY_CYC), .SCAN_CYC(SCAN_CYC)) mfla_core_chk_i (
    .sys_clk(sys_clk), .reset(reset), .power_fail_warning(power_fail_warning),
    .power_on_event(power_on_event), .io_reset(io_reset), .cmd(cmd),
    .refresh_window(refresh_window), .map_rdata(map_rdata), .map_port(map_port),
    .ecc_write_disable(ecc_write_disable), .status_word(status_word),
    .scan_result_word(scan_result_word));
